// ### rtl/iwt_pkg.sv
package iwt_pkg;
	// ----------------------------------------
	// register index (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [1:0]  IDX_TIMEOUT   = 2'h0;
	localparam logic [1:0]  IDX_MASK      = 2'h1;
	localparam logic [1:0]  IDX_STATUS    = 2'h2;
	localparam logic [1:0]  IDX_RSVD      = 2'h3;
	localparam logic [7:0]  IDX_EVT_STAT  = 8'h04;
	localparam logic [7:0]  IDX_EVT_MASK  = 8'h05;
	localparam int          ADDR_LSB      = 2;
	localparam int          ADDR_W        = 8;
	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam logic [7:0]  TIMEOUT_RST   = 8'h00;
	localparam logic [7:0]  MASK_RST      = 8'h00;
	localparam logic [7:0]  STATUS_RST    = 8'h01;
	localparam logic [7:0]  MASK_VALID    = 8'h0F;
	localparam int          UNIT_HI_BIT   = 7;
	localparam int          UNIT_LO_BIT   = 2;
	localparam int          EXP_BIT       = 0;
	localparam int          EVT_W         = 2;
	localparam int          EVT_EXPIRE    = 0;
	localparam int          EVT_TRIGGER   = 1;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int          CLK_HZ        = 100_000_000;
	localparam int          SECOND_S      = 1;
	localparam int          MINUTE_S      = 60;
	localparam int          SEC_CYCLES    = CLK_HZ * SECOND_S;
	typedef enum logic {IWT_IDLE, IWT_RUN} iwt_state_t;
endpackage

// ### rtl/iwt_inactivity_timer.sv
`timescale 1ns/1ps
// Functional notes
// - timeout, mask, status at offsets 0-2
// - timeout holds 8-bit period 1..255
// - timeout write releases expiry, status bit set
// - nonzero write when idle starts counting
// - nonzero write while counting reloads counter
// - zero write stops timer, expiry outputs inactive
// - reset clears timeout, timer inactive
// - mask bits 3..0 enable four triggers
// - enabled trigger reloads counter from timeout while counting
// - status becomes 01h on reset, bit 0 set on activation
// - status bit 0 mirrors expiry level
// - status bits 7,2 select seconds unit
// - counter decrements per minute or second
// - zero count stops, asserts expiry low
// - routed irq active while expiry active
// - all triggers masked after reset
module iwt_inactivity_timer
	import iwt_pkg::*;
#(
	parameter int SEC_CNT = SEC_CYCLES,
	parameter int MIN_SECS = MINUTE_S
)
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  trigger_irq,
	input  wire logic        irq_route_en,
	output logic             expiry_output_n,
	output logic             expiry_irq,
	output logic             irq
);
	// ----------------------------------------
	// reset synchroniser
	// ----------------------------------------
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic [ADDR_W-1:0] idx;
	logic              acc;
	logic              wr;
	logic              rd_setup;
	assign idx     = paddr[ADDR_LSB +: ADDR_W];
	assign rd_setup = psel && !penable && !pwrite;
	assign acc     = psel && penable;
	assign wr      = acc && pwrite && pstrb[0];
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
		hit = (a == r);
	endfunction

	logic wr_to, wr_msk, wr_st, wr_es, wr_em;
	assign wr_to  = wr && hit(idx, ADDR_W'(IDX_TIMEOUT));
	assign wr_msk = wr && hit(idx, ADDR_W'(IDX_MASK));
	assign wr_st  = wr && hit(idx, ADDR_W'(IDX_STATUS));
	assign wr_es  = wr && hit(idx, IDX_EVT_STAT);
	assign wr_em  = wr && hit(idx, IDX_EVT_MASK);

	// ----------------------------------------
	// timer state
	// ----------------------------------------
	iwt_state_t state, next_state;
	logic [7:0]  timeout_period_reg, next_timeout;
	logic [7:0]  trigger_mask_reg, next_mask;
	logic        unit_hi, next_unit_hi, unit_lo, next_unit_lo;
	logic        expired, next_expired;
	logic [7:0]  count, next_count;
	logic [31:0] pre, next_pre;
	logic [7:0]  secs, next_secs;
	logic [3:0]  trig_q, next_trig_q;
	logic [EVT_W-1:0] evt_stat, next_evt_stat, evt_mask, next_evt_mask, evt_set;
	logic [31:0] next_prdata;
	logic        sec_tick, unit_tick, trig_hit, seconds;

	assign seconds  = unit_hi && unit_lo;
	assign sec_tick = (pre == 32'(SEC_CNT - 1));
	assign unit_tick = sec_tick && (seconds || secs == 8'(MIN_SECS - 1));
	assign trig_hit = |(trigger_irq & ~trig_q & trigger_mask_reg[3:0]);

	always_comb
	begin
		next_state    = state;
		next_timeout  = timeout_period_reg;
		next_mask     = trigger_mask_reg;
		next_unit_hi  = unit_hi;
		next_unit_lo  = unit_lo;
		next_expired  = expired;
		next_count    = count;
		next_pre      = sec_tick ? 32'h0 : pre + 32'h1;
		next_secs     = secs;
		next_trig_q   = trigger_irq;
		evt_set       = '0;
		if (sec_tick)
			next_secs = (secs == 8'(MIN_SECS - 1)) ? 8'h00 : secs + 8'h01;
		unique case (state)
			IWT_IDLE:
			begin
			end
			IWT_RUN:
			begin
				if (trig_hit)
				begin
					next_count = timeout_period_reg;
					evt_set[EVT_TRIGGER] = 1'b1;
				end
				else if (unit_tick)
				begin
					if (count == 8'h01)
					begin
						next_count   = 8'h00;
						next_expired = 1'b1;
						next_state   = IWT_IDLE;
						evt_set[EVT_EXPIRE] = 1'b1;
					end
					else
						next_count = count - 8'h01;
				end
			end
		endcase
		if (wr_msk)
			next_mask = pwdata[7:0] & MASK_VALID;
		if (wr_st)
		begin
			next_unit_hi = pwdata[UNIT_HI_BIT];
			next_unit_lo = pwdata[UNIT_LO_BIT];
		end
		if (wr_to)
		begin
			next_timeout = pwdata[7:0];
			next_expired = 1'b0;
			next_count   = pwdata[7:0];
			next_state   = (pwdata[7:0] != 8'h00) ? IWT_RUN : IWT_IDLE;
			next_pre     = 32'h0;
			next_secs    = 8'h00;
			evt_set      = '0;
		end
		next_evt_mask = wr_em ? pwdata[EVT_W-1:0] : evt_mask;
		next_evt_stat = (evt_stat & ~(wr_es ? pwdata[EVT_W-1:0] : '0)) | evt_set;
	end

	always_comb
	begin
		next_prdata = prdata;
		if (rd_setup)
		begin
			next_prdata = 32'h0;
			if (hit(idx, ADDR_W'(IDX_TIMEOUT)))
				next_prdata[7:0] = timeout_period_reg;
			else if (hit(idx, ADDR_W'(IDX_MASK)))
				next_prdata[7:0] = trigger_mask_reg;
			else if (hit(idx, ADDR_W'(IDX_STATUS)))
			begin
				next_prdata[UNIT_HI_BIT] = unit_hi;
				next_prdata[UNIT_LO_BIT] = unit_lo;
				next_prdata[EXP_BIT]     = ~expired;
			end
			else if (hit(idx, IDX_EVT_STAT))
				next_prdata[EVT_W-1:0] = evt_stat;
			else if (hit(idx, IDX_EVT_MASK))
				next_prdata[EVT_W-1:0] = evt_mask;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state              <= IWT_IDLE;
			timeout_period_reg <= TIMEOUT_RST;
			trigger_mask_reg   <= MASK_RST;
			unit_hi            <= STATUS_RST[UNIT_HI_BIT];
			unit_lo            <= STATUS_RST[UNIT_LO_BIT];
			expired            <= ~STATUS_RST[EXP_BIT];
			count              <= TIMEOUT_RST;
			pre                <= 32'h0;
			secs               <= 8'h00;
			trig_q             <= 4'h0;
			evt_stat           <= '0;
			evt_mask           <= '0;
			prdata             <= 32'h0;
		end
		else
		begin
			state              <= next_state;
			timeout_period_reg <= next_timeout;
			trigger_mask_reg   <= next_mask;
			unit_hi            <= next_unit_hi;
			unit_lo            <= next_unit_lo;
			expired            <= next_expired;
			count              <= next_count;
			pre                <= next_pre;
			secs               <= next_secs;
			trig_q             <= next_trig_q;
			evt_stat           <= next_evt_stat;
			evt_mask           <= next_evt_mask;
			prdata             <= next_prdata;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign expiry_output_n = ~expired;
	assign expiry_irq      = irq_route_en && expired;
	assign irq             = |(evt_stat & evt_mask);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	AST_TO_WRITE_RELEASE: assert property (wr_to |=> expiry_output_n)
		else $error("timeout write did not release expiry");
	AST_START: assert property (wr_to && pwdata[7:0] != 8'h00 |=> state == IWT_RUN && count == $past(pwdata[7:0]))
		else $error("nonzero write did not start timer");
	AST_RELOAD: assert property (state == IWT_RUN && wr_to && pwdata[7:0] != 8'h00 |=> count == $past(pwdata[7:0]))
		else $error("running reload wrong");
	AST_STOP: assert property (wr_to && pwdata[7:0] == 8'h00 |=> state == IWT_IDLE && !expiry_irq)
		else $error("zero write did not stop timer");
	AST_TRIG: assert property (state == IWT_RUN && trig_hit && !wr_to |=> count == timeout_period_reg)
		else $error("trigger did not reload");
	AST_EXPIRE: assert property (state == IWT_RUN && count == 8'h01 && unit_tick && !trig_hit && !wr_to
		|=> !expiry_output_n && state == IWT_IDLE)
		else $error("expiry not asserted");
	AST_MIRROR: assert property (rd_setup && hit(idx, ADDR_W'(IDX_STATUS)) |=> prdata[EXP_BIT] == $past(expiry_output_n))
		else $error("status bit 0 mismatch");
	AST_IRQ_ROUTE: assert property (expiry_irq == (irq_route_en && !expiry_output_n))
		else $error("routed irq mismatch");
	AST_MASK_RSVD: assert property (trigger_mask_reg[7:4] == 4'h0)
		else $error("mask reserved bits set");
	AST_RUN_NONZERO: assert property (state == IWT_RUN |-> count != 8'h00)
		else $error("running with zero count");
	AST_IDLE_HOLD: assert property (state == IWT_IDLE && !wr_to |=> count == $past(count))
		else $error("idle counter moved");
	AST_QUIET_HOLD: assert property (state == IWT_RUN && !wr_to && !unit_tick && !trig_hit |=> count == $past(count))
		else $error("counter moved without tick or trigger");
	AST_UNIT_WRITE: assert property (wr_st |=> unit_hi == $past(pwdata[UNIT_HI_BIT]) && unit_lo == $past(pwdata[UNIT_LO_BIT]))
		else $error("time unit write not stored");
	AST_MASK_WRITE: assert property (wr_msk |=> trigger_mask_reg == ($past(pwdata[7:0]) & MASK_VALID))
		else $error("mask write not stored");
	AST_EXP_STICKY: assert property (!expiry_output_n && !wr_to |=> !expiry_output_n)
		else $error("expiry released without timeout write");
	AST_TICK_DEC: assert property (state == IWT_RUN && unit_tick && count > 8'h01 && !trig_hit && !wr_to
		|=> count == $past(count) - 8'h01)
		else $error("counter did not decrement on tick");
	AST_EVT_SET_WINS: assert property (evt_set[EVT_EXPIRE] |=> evt_stat[EVT_EXPIRE])
		else $error("expiry event not recorded");
	AST_PRE_RANGE: assert property (pre < 32'(SEC_CNT))
		else $error("prescaler out of range");
	AST_TO_STORE: assert property (wr_to |=> timeout_period_reg == $past(pwdata[7:0]))
		else $error("timeout write not stored");
	AST_RSVD_READ: assert property (rd_setup && hit(idx, ADDR_W'(IDX_RSVD)) |=> prdata == 32'h0)
		else $error("reserved offset read not zero");
	AST_STATUS_RSVD: assert property (rd_setup && hit(idx, ADDR_W'(IDX_STATUS)) |=> prdata[6:3] == 4'h0 && !prdata[1])
		else $error("status reserved bits not zero");
	AST_SEC_TICK: assert property (seconds && sec_tick |-> unit_tick)
		else $error("seconds tick missing");
	AST_MIN_TICK: assert property (!seconds && unit_tick |-> secs == 8'(MIN_SECS - 1))
		else $error("minute tick early");

	// ----------------------------------------
	// cover points
	// ----------------------------------------
	COV_START: cover property (wr_to && pwdata[7:0] != 8'h00);
	COV_RELOAD_WRITE: cover property (wr_to && state == IWT_RUN);
	COV_TRIG: cover property (state == IWT_RUN && trig_hit);
	COV_EXPIRE: cover property ($fell(expiry_output_n));
	COV_SECONDS: cover property (seconds && state == IWT_RUN);
endmodule

// ### verif/iwt_irq_src.sv
`timescale 1ns/1ps
module iwt_irq_src
(
	input  wire logic       mclk,
	input  wire logic [3:0] fire,
	output logic      [3:0] trigger_irq
);
	// --------------------------------
	// peripheral request lines, held two cycles a request
	// --------------------------------
	logic [3:0] hold;
	initial
	begin
		hold = 4'h0;
		trigger_irq = 4'h0;
	end
	always @(posedge mclk)
	begin
		hold <= fire;
		trigger_irq <= fire | hold;
	end
endmodule

// ### verif/tb_iwt_inactivity_timer.sv
`timescale 1ns/1ps
module tb_iwt_inactivity_timer
	import iwt_pkg::*;
;
	logic        mclk, reset_n, psel, penable, pwrite, irq_route_en;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0]  pstrb, fire, trigger_irq;
	logic        pready, pslverr, expiry_output_n, expiry_irq, irq;
	int          fails, n_checks, cyc;
	iwt_inactivity_timer #(.SEC_CNT(10), .MIN_SECS(3)) i_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trigger_irq(trigger_irq), .irq_route_en(irq_route_en),
		.expiry_output_n(expiry_output_n), .expiry_irq(expiry_irq), .irq(irq));
	iwt_irq_src i_src (.mclk(mclk), .fire(fire), .trigger_irq(trigger_irq));
	initial
	begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	// --------------------------------
	// report and hang guard
	// --------------------------------
	task give_verdict;
		$display("fails=%0d n_checks=%0d", fails, n_checks);
		if (fails == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			fails = fails + 1;
			$display("mismatch at %0t: run too long", $time);
			give_verdict;
		end
	end
	// --------------------------------
	// apb master and compares
	// --------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chkp(input logic [2:0] exp);
		chk({29'h0, expiry_output_n, expiry_irq, irq}, {29'h0, exp});
	endtask
	task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {22'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		psel <= 0;
		penable <= 0;
		rd = prdata;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1, idx, d);
	endtask
	task rdc(input logic [7:0] idx, input logic [7:0] exp);
		apb(0, idx, 8'h00);
		chk(rd, {24'h0, exp});
	endtask
	task idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task kick(input logic [3:0] f);
		wr(8'h00, 8'h02);
		idle(14);
		fire <= f;
		idle(1);
		fire <= 4'h0;
		idle(12);
	endtask
	// --------------------------------
	// tests
	// --------------------------------
	initial
	begin
		reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		pstrb = 4'hF; fire = 4'h0; irq_route_en = 0; fails = 0; n_checks = 0; cyc = 0;
		idle(10);
		reset_n <= 1;
		idle(3);
		rdc(8'h00, 8'h00);
		rdc(8'h01, 8'h00);
		rdc(8'h02, 8'h01);
		wr(8'h03, 8'hFF);
		rdc(8'h03, 8'h00);
		wr(8'h01, 8'hFF);
		rdc(8'h01, 8'h0F);
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h01);
		rdc(8'h00, 8'h01);
		idle(15);
		chkp(3'b100);
		idle(25);
		chkp(3'b000);
		rdc(8'h02, 8'h00);
		irq_route_en <= 1;
		idle(2);
		chkp(3'b010);
		wr(IDX_EVT_MASK, 8'h01);
		idle(2);
		chkp(3'b011);
		wr(IDX_EVT_STAT, 8'h01);
		idle(2);
		chkp(3'b010);
		wr(8'h00, 8'h00);
		idle(1);
		chkp(3'b100);
		rdc(8'h02, 8'h01);
		wr(8'h02, 8'h80);
		wr(8'h02, 8'h84);
		rdc(8'h02, 8'h85);
		wr(8'h00, 8'h03);
		idle(20);
		chkp(3'b100);
		idle(20);
		chkp(3'b011);
		wr(IDX_EVT_MASK, 8'h00);
		wr(IDX_EVT_STAT, 8'h03);
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h01, 8'h01 << k);
			kick(4'h1 << k);
			chkp(3'b100);
		end
		wr(8'h01, 8'h00);
		kick(4'hF);
		chkp(3'b010);
		give_verdict;
	end
endmodule
